// [lrgg_pkg.sv]
`default_nettype none
package lrgg_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 8;
    localparam int BSD_NS = 400;
    // Least settle delay: round up to whole cycles
    localparam int BSD_CYC = (BSD_NS + CLK_NS - 1) / CLK_NS;
    localparam int STABLE_MS = 100;
    localparam int NS_PER_MS = 1000000;
    localparam int STABLE_CYC = (STABLE_MS * NS_PER_MS) / CLK_NS;
    localparam int CNT_W = 24;
    localparam int DATA_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Sensed transmission mode; codes match the comparator pins
    typedef enum logic [1:0] {
        MODE_SE = 2'h0,
        MODE_LVD = 2'h1,
        MODE_HVD = 2'h2,
        MODE_UNK = 2'h3
    } lrgg_mode_e;

    // ------------------------------------------------------------
    // Multiples of the settle delay
    // ------------------------------------------------------------
    // Least wait of 2.5 delays, rounded up
    function automatic logic [CNT_W-1:0] lrgg_wait_x25(input int bsd);
        lrgg_wait_x25 = CNT_W'((5 * bsd + 1) / 2);
    endfunction

    // Longest reaction of 1.5 delays, rounded down, at least one
    function automatic logic [CNT_W-1:0] lrgg_limit_x15(input int bsd);
        lrgg_limit_x15 = ((3 * bsd) / 2 < 1) ? CNT_ONE : CNT_W'((3 * bsd) / 2);
    endfunction

    // Count minus one at counter width
    function automatic logic [CNT_W-1:0] lrgg_last(input int cyc);
        lrgg_last = (cyc < 1) ? CNT_ZERO : CNT_W'(cyc - 1);
    endfunction
endpackage
`default_nettype wire

// [lrgg_bus_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface lrgg_bus_if import lrgg_pkg::*; ();
    // ------------------------------------------------------------
    // Per-party drive: Oe high while driving, Val is driven level
    // ------------------------------------------------------------
    logic tBsyOe;
    logic tReqOe;
    logic tReqVal;
    logic tCdOe;
    logic tCdVal;
    logic tIoOe;
    logic tIoVal;
    logic tMsgOe;
    logic tMsgVal;
    logic [DATA_W-1:0] tDataOe;
    logic [DATA_W-1:0] tDataVal;
    logic iSelOe;
    logic iRstOe;
    logic iAckOe;
    logic iAckVal;
    logic iAtnOe;
    logic iAtnVal;
    logic [DATA_W-1:0] iDataOe;
    logic [DATA_W-1:0] iDataVal;
    // Comparator code from the mode sense line, driven from outside
    logic [1:0] diffSense;

    // ------------------------------------------------------------
    // Resolved true levels; released lines fall back to false
    // ------------------------------------------------------------
    logic bsy;
    logic sel;
    logic rst;
    logic req;
    logic ack;
    logic atn;
    logic cd;
    logic io;
    logic msg;
    logic [DATA_W-1:0] data;
    // BSY, SEL and RST are assert-only: an enable means true; the rest AND Oe with Val
    assign bsy = tBsyOe;
    assign sel = iSelOe;
    assign rst = iRstOe;
    assign req = tReqOe & tReqVal;
    assign cd = tCdOe & tCdVal;
    assign io = tIoOe & tIoVal;
    assign msg = tMsgOe & tMsgVal;
    assign ack = iAckOe & iAckVal;
    assign atn = iAtnOe & iAtnVal;
    assign data = (tDataOe & tDataVal) | (iDataOe & iDataVal);

    modport target (
        output tBsyOe, tReqOe, tReqVal, tCdOe, tCdVal, tIoOe, tIoVal,
        output tMsgOe, tMsgVal, tDataOe, tDataVal,
        input ack, atn, diffSense
    );
    modport initiator (
        output iSelOe, iRstOe, iAckOe, iAckVal, iAtnOe, iAtnVal,
        output iDataOe, iDataVal,
        input bsy, sel, req
    );
endinterface // lrgg_bus_if
`default_nettype wire

// [lrgg_initiator.sv]
`timescale 1ns/1ps
`default_nettype none
module lrgg_initiator import lrgg_pkg::*; #(
    parameter int BSD_CYCLES = BSD_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    lrgg_bus_if.initiator bus,
    input wire logic selReq,
    input wire logic selPhase,
    input wire logic ackVal,
    input wire logic atnVal,
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic dataDrive,
    input wire logic rstReq,
    output logic reqSeen,
    output logic busFree,
    output logic engaged
);
    // ------------------------------------------------------------
    // Bus input synchronisers
    // ------------------------------------------------------------
    logic bsyS1_r, bsyS2_r, bsyPrev_r;
    logic selS1_r, selS2_r;
    logic reqS1_r, reqS2_r;
    logic ignoreReq_r, ignoreReq_nxt;
    logic [CNT_W-1:0] freeCnt_r, freeCnt_nxt;
    logic busFree_nxt, engaged_nxt;
    logic bsyFell, bsyRose, busHeld;
    logic [CNT_W-1:0] freeLast;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bsyS1_r <= 1'b0;
            bsyS2_r <= 1'b0;
            bsyPrev_r <= 1'b0;
            selS1_r <= 1'b0;
            selS2_r <= 1'b0;
            reqS1_r <= 1'b0;
            reqS2_r <= 1'b0;
        end else begin
            bsyS1_r <= bus.bsy;
            bsyS2_r <= bsyS1_r;
            bsyPrev_r <= bsyS2_r;
            selS1_r <= bus.sel;
            selS2_r <= selS1_r;
            reqS1_r <= bus.req;
            reqS2_r <= reqS1_r;
        end
    end

    // ------------------------------------------------------------
    // Bus free and ignore decisions
    // ------------------------------------------------------------
    // Two sync stages plus one cycle stay well inside 1.5 delays
    assign bsyFell = bsyPrev_r & ~bsyS2_r;
    assign bsyRose = ~bsyPrev_r & bsyS2_r;
    assign ignoreReq_nxt = bsyFell | (ignoreReq_r & ~bsyRose); // [RULE_06]
    assign busHeld = bsyS2_r | selS2_r;
    assign freeLast = lrgg_last(BSD_CYCLES);
    // Free only after one full delay with both lines false
    assign freeCnt_nxt = busHeld ? CNT_ZERO :
        (freeCnt_r == freeLast) ? freeCnt_r : freeCnt_r + CNT_ONE; // [RULE_09]
    assign busFree_nxt = ~busHeld & (freeCnt_r == freeLast); // [RULE_09]
    // Keep ACK and ATN driven until the bus is really free
    assign engaged_nxt = selReq | (engaged & ~busFree_nxt); // [RULE_03]

    // ------------------------------------------------------------
    // Registered outputs and bus drive
    // ------------------------------------------------------------
    // SEL and RST are assert-only; passive negation by termination
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ignoreReq_r <= 1'b1;
            freeCnt_r <= CNT_ZERO;
            busFree <= 1'b0;
            engaged <= 1'b0;
            reqSeen <= 1'b0;
            bus.iSelOe <= 1'b0;
            bus.iRstOe <= 1'b0;
            bus.iAckOe <= 1'b0;
            bus.iAckVal <= 1'b0;
            bus.iAtnOe <= 1'b0;
            bus.iAtnVal <= 1'b0;
            bus.iDataOe <= '0;
            bus.iDataVal <= '0;
        end else begin
            ignoreReq_r <= ignoreReq_nxt;
            freeCnt_r <= freeCnt_nxt;
            busFree <= busFree_nxt;
            engaged <= engaged_nxt;
            reqSeen <= reqS2_r & ~ignoreReq_nxt; // [RULE_06]
            bus.iSelOe <= selReq; // [RULE_14]
            bus.iRstOe <= rstReq; // [RULE_14]
            bus.iAckOe <= engaged_nxt; // [RULE_03]
            bus.iAckVal <= engaged_nxt & ~ignoreReq_nxt & ackVal; // [RULE_03]
            bus.iAtnOe <= engaged_nxt; // [RULE_03]
            bus.iAtnVal <= engaged_nxt & ~ignoreReq_nxt & atnVal; // [RULE_03]
            // Selection: only true bits driven, false bits released
            bus.iDataOe <= selPhase ? dataOut : {DATA_W{dataDrive}}; // [RULE_08]
            bus.iDataVal <= dataOut;
        end
    end
endmodule // lrgg_initiator
`default_nettype wire

// [lrgg_target.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE_01] LVD drive uses release glitch management always
// [RULE_02] Receivers tolerate one-delay true glitches
// [RULE_03] Initiator releases ACK/ATN only at bus free
// [RULE_04] Target ignores ACK/ATN after BSY release
// [RULE_05] REQ released 2.5 delays after BSY
// [RULE_06] Initiator ignores REQ within 1.5 delays
// [RULE_07] C/D, I/O, MSG held until BSY released
// [RULE_08] Selection: false data bits are released
// [RULE_09] Bus free one delay after BSY/SEL false
// [RULE_10] Monitor mode sense line for bus mode
// [RULE_11] Mode change needs 100 ms continuous sensing
// [RULE_12] Drivers off until 100 ms plus stable mode; only the target holds off, initiator drivers are not gated
// [RULE_13] Settle delay is a cycle count parameter
// [RULE_14] BSY, SEL, RST never actively negated
module lrgg_target import lrgg_pkg::*; #(
    parameter int BSD_CYCLES = BSD_CYC, // [RULE_13]
    parameter int STABLE_CYCLES = STABLE_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    lrgg_bus_if.target bus,
    input wire logic connReq,
    input wire logic reselPhase,
    input wire logic reqVal,
    input wire logic cdVal,
    input wire logic ioVal,
    input wire logic msgVal,
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic dataDrive,
    output logic ackSeen,
    output logic atnSeen,
    output logic ignoring,
    output logic drvReady,
    output logic [1:0] busMode,
    output logic connected
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {T_IDLE, T_CONN, T_DROP} lrgg_tstate_e;
    lrgg_tstate_e state_r, state_nxt;
    logic [CNT_W-1:0] dropCnt_r, dropCnt_nxt;
    logic [CNT_W-1:0] reqLast, stableLast;
    logic ackS1_r, ackS2_r, atnS1_r, atnS2_r;
    logic [1:0] senseS1_r, senseS2_r, senseHeld_r;
    logic [CNT_W-1:0] puCnt_r, modeCnt_r, modeCnt_nxt;
    logic puDone_r, puDone_nxt;
    logic senseMoved, modeStable, drvReady_nxt;
    logic ignoring_nxt, connNxt, dropNxt, phaseHold;
    logic cdHeld_r, ioHeld_r, msgHeld_r;
    logic cdNxt, ioNxt, msgNxt;
    logic [1:0] busMode_nxt;

    assign reqLast = lrgg_wait_x25(BSD_CYCLES) - CNT_ONE; // [RULE_05]
    assign stableLast = lrgg_last(STABLE_CYCLES);

    // ------------------------------------------------------------
    // Synchronisers for bus lines and mode sense code
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ackS1_r <= 1'b0;
            ackS2_r <= 1'b0;
            atnS1_r <= 1'b0;
            atnS2_r <= 1'b0;
            senseS1_r <= MODE_SE;
            senseS2_r <= MODE_SE;
            senseHeld_r <= MODE_SE;
        end else begin
            ackS1_r <= bus.ack;
            ackS2_r <= ackS1_r;
            atnS1_r <= bus.atn;
            atnS2_r <= atnS1_r;
            senseS1_r <= bus.diffSense; // [RULE_10]
            senseS2_r <= senseS1_r;
            senseHeld_r <= senseS2_r;
        end
    end

    // ------------------------------------------------------------
    // Mode qualifier and power-on driver hold-off
    // ------------------------------------------------------------
    // Separate counters serve the power-on wait (puCnt_r) and the
    // stability check (modeCnt_r); indeterminate codes count as a mode of
    // their own, so they restart the window but are never adopted
    assign puDone_nxt = puDone_r | (puCnt_r == stableLast); // [RULE_12]
    assign senseMoved = (senseS2_r != senseHeld_r);
    assign modeStable = (modeCnt_r == stableLast);
    // Window restarts on any change and again when power-on ends
    assign modeCnt_nxt = (senseMoved | ~puDone_r) ? CNT_ZERO :
        modeStable ? modeCnt_r : modeCnt_r + CNT_ONE; // [RULE_11]
    assign busMode_nxt = (modeStable & (senseHeld_r != MODE_UNK)) ?
        senseHeld_r : busMode; // [RULE_11]
    assign drvReady_nxt = drvReady | (puDone_r & modeStable); // [RULE_12]

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            puCnt_r <= CNT_ZERO;
            puDone_r <= 1'b0;
            modeCnt_r <= CNT_ZERO;
            busMode <= MODE_SE;
            drvReady <= 1'b0;
        end else begin
            puCnt_r <= puDone_nxt ? puCnt_r : puCnt_r + CNT_ONE; // [RULE_12]
            puDone_r <= puDone_nxt;
            modeCnt_r <= modeCnt_nxt;
            busMode <= busMode_nxt;
            drvReady <= drvReady_nxt;
        end
    end

    // ------------------------------------------------------------
    // Connection sequencer
    // ------------------------------------------------------------
    // A new connection waits for the REQ release to finish, so a
    // drop sequence can never be cut short
    always_comb begin
        state_nxt = state_r;
        dropCnt_nxt = dropCnt_r;
        case (state_r)
            T_IDLE: begin
                if (connReq && drvReady) begin
                    state_nxt = T_CONN;
                end
            end
            T_CONN: begin
                if (!connReq) begin
                    state_nxt = T_DROP;
                    dropCnt_nxt = CNT_ZERO;
                end
            end
            T_DROP: begin
                dropCnt_nxt = dropCnt_r + CNT_ONE;
                if (dropCnt_r >= reqLast) begin
                    state_nxt = T_IDLE; // [RULE_05]
                end
            end
            default: begin
                state_nxt = T_IDLE;
            end
        endcase
    end

    assign connNxt = (state_nxt == T_CONN);
    assign dropNxt = (state_nxt == T_DROP);
    // Phase lines stay driven through the cycle BSY goes away
    assign phaseHold = connNxt | (dropNxt & (dropCnt_nxt == CNT_ZERO)); // [RULE_07]
    assign cdNxt = connNxt ? cdVal : cdHeld_r;
    assign ioNxt = connNxt ? ioVal : ioHeld_r;
    assign msgNxt = connNxt ? msgVal : msgHeld_r;
    // Ignore starts with the BSY release itself, ends at next connection
    assign ignoring_nxt = dropNxt | (ignoring & ~connNxt); // [RULE_04]

    // ------------------------------------------------------------
    // Registered outputs and bus drive
    // ------------------------------------------------------------
    // Glitch handling is applied in every mode, not only LVD
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= T_IDLE;
            dropCnt_r <= CNT_ZERO;
            cdHeld_r <= 1'b0;
            ioHeld_r <= 1'b0;
            msgHeld_r <= 1'b0;
            ignoring <= 1'b1;
            connected <= 1'b0;
            ackSeen <= 1'b0;
            atnSeen <= 1'b0;
            bus.tBsyOe <= 1'b0;
            bus.tReqOe <= 1'b0;
            bus.tReqVal <= 1'b0;
            bus.tCdOe <= 1'b0;
            bus.tCdVal <= 1'b0;
            bus.tIoOe <= 1'b0;
            bus.tIoVal <= 1'b0;
            bus.tMsgOe <= 1'b0;
            bus.tMsgVal <= 1'b0;
            bus.tDataOe <= '0;
            bus.tDataVal <= '0;
        end else begin
            state_r <= state_nxt;
            dropCnt_r <= dropCnt_nxt;
            cdHeld_r <= cdNxt;
            ioHeld_r <= ioNxt;
            msgHeld_r <= msgNxt;
            ignoring <= ignoring_nxt;
            connected <= connNxt;
            ackSeen <= ackS2_r & ~ignoring_nxt; // [RULE_04]
            atnSeen <= atnS2_r & ~ignoring_nxt; // [RULE_04]
            bus.tBsyOe <= connNxt & drvReady_nxt; // [RULE_14]
            // REQ negated actively through the whole drop wait
            bus.tReqOe <= (connNxt | dropNxt) & drvReady_nxt; // [RULE_05]
            bus.tReqVal <= connNxt & reqVal; // [RULE_01]
            bus.tCdOe <= phaseHold & drvReady_nxt; // [RULE_07]
            bus.tCdVal <= cdNxt;
            bus.tIoOe <= phaseHold & drvReady_nxt; // [RULE_07]
            bus.tIoVal <= ioNxt;
            bus.tMsgOe <= phaseHold & drvReady_nxt; // [RULE_07]
            bus.tMsgVal <= msgNxt;
            // Reselection: only true bits driven, false bits released
            bus.tDataOe <= (connNxt & drvReady_nxt) ?
                (reselPhase ? dataOut : {DATA_W{dataDrive}}) : '0; // [RULE_08]
            bus.tDataVal <= dataOut;
        end
    end
endmodule // lrgg_target
`default_nettype wire

// [lrgg_dummy_end.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [lrgg_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Checker on the shared bus signals
// ------------------------------------------------------------
module lrgg_sva import lrgg_pkg::*; #(
    parameter int BSD_CYCLES = BSD_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic tBsyOe,
    input wire logic tReqOe,
    input wire logic tReqVal,
    input wire logic tCdOe,
    input wire logic tIoOe,
    input wire logic tMsgOe,
    input wire logic iAckOe,
    input wire logic iAckVal,
    input wire logic iAtnOe,
    input wire logic iAtnVal,
    input wire logic [DATA_W-1:0] iDataOe,
    input wire logic [DATA_W-1:0] iDataVal,
    input wire logic bsy,
    input wire logic sel
);
    localparam int WAIT = (5 * BSD_CYCLES + 1) / 2;
    logic [15:0] freeCnt_r;
    logic [15:0] relCnt_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // Idle-bus and BSY-release ages; saturate so a long idle never wraps
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            freeCnt_r <= 16'h0000;
            relCnt_r <= 16'hffff;
        end else begin
            freeCnt_r <= (bsy || sel) ? 16'h0000 : freeCnt_r + {15'h0000, freeCnt_r != 16'hffff};
            relCnt_r <= tBsyOe ? 16'h0000 : relCnt_r + {15'h0000, relCnt_r != 16'hffff};
        end
    end

    a_ack_free_release: assert property ($fell(iAckOe) |-> freeCnt_r >= BSD_CYCLES)
        else $error("ACK drive dropped before bus free");
    a_atn_free_release: assert property ($fell(iAtnOe) |-> freeCnt_r >= BSD_CYCLES)
        else $error("ATN drive dropped before bus free");
    a_ack_negated_off: assert property (
        ($fell(bsy) && iAckOe) |-> ##4 (!iAckOe || (!iAckVal && !iAtnVal)))
        else $error("ACK or ATN not negated after BSY fell");
    a_req_neg_hold: assert property (
        (!tBsyOe && relCnt_r < WAIT) |-> (tReqOe && !tReqVal))
        else $error("REQ not held negated after BSY release");
    a_req_release_due: assert property (
        (!tBsyOe && relCnt_r == WAIT + 2) |-> !tReqOe)
        else $error("REQ still driven long after wait");
    a_reconnect_gap: assert property ($rose(tBsyOe) |-> relCnt_r >= WAIT)
        else $error("BSY taken again before REQ wait ended");
    a_phase_after_bsy: assert property (
        ($fell(tCdOe) || $fell(tIoOe) || $fell(tMsgOe)) |-> !tBsyOe)
        else $error("Phase line released while BSY driven");
    a_sel_false_released: assert property (
        (sel && !bsy) |-> (iDataOe & ~iDataVal) == '0)
        else $error("False data bit negated during selection");
endmodule // lrgg_sva
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb import lrgg_pkg::*; ;
    localparam int BSD = 4;
    localparam int STB = 20;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic connReq, reselPhase, reqVal, cdVal, ioVal, msgVal, tDrive;
    logic [7:0] tData, iData;
    logic selReq, selPhase, ackVal, atnVal, iDrive, rstReq;
    logic ackSeen, atnSeen, ignoring, drvReady, connected, reqSeen, busFree, engaged;
    logic [1:0] busMode;
    int err_count = 0;
    int tests_run = 0;
    int seed, k, i, n;

    // ------------------------------------------------------------
    // Both ends joined through the bus
    // ------------------------------------------------------------
    always #4 core_clk = ~core_clk;
    lrgg_bus_if bus ();
    lrgg_target #(.BSD_CYCLES(BSD), .STABLE_CYCLES(STB)) u_lrgg_target (.core_clk(core_clk),
        .arst_n(arst_n), .bus(bus), .connReq(connReq), .reselPhase(reselPhase), .reqVal(reqVal),
        .cdVal(cdVal), .ioVal(ioVal), .msgVal(msgVal), .dataOut(tData), .dataDrive(tDrive),
        .ackSeen(ackSeen), .atnSeen(atnSeen), .ignoring(ignoring), .drvReady(drvReady),
        .busMode(busMode), .connected(connected));
    lrgg_initiator #(.BSD_CYCLES(BSD)) u_lrgg_initiator (.core_clk(core_clk), .arst_n(arst_n),
        .bus(bus), .selReq(selReq), .selPhase(selPhase), .ackVal(ackVal), .atnVal(atnVal),
        .dataOut(iData), .dataDrive(iDrive), .rstReq(rstReq), .reqSeen(reqSeen),
        .busFree(busFree), .engaged(engaged));
    lrgg_sva #(.BSD_CYCLES(BSD)) u_lrgg_sva (.core_clk(core_clk), .arst_n(arst_n),
        .tBsyOe(bus.tBsyOe), .tReqOe(bus.tReqOe), .tReqVal(bus.tReqVal), .tCdOe(bus.tCdOe),
        .tIoOe(bus.tIoOe), .tMsgOe(bus.tMsgOe), .iAckOe(bus.iAckOe), .iAckVal(bus.iAckVal),
        .iAtnOe(bus.iAtnOe), .iAtnVal(bus.iAtnVal), .iDataOe(bus.iDataOe),
        .iDataVal(bus.iDataVal), .bsy(bus.bsy), .sel(bus.sel));

    // ------------------------------------------------------------
    // Helpers; inputs always move 1 ns after the edge
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    // Hold a sense code, then see which mode was adopted
    task automatic mode_step(input logic [1:0] code, input int c, input lrgg_mode_e exp);
        bus.diffSense = code;
        tick(c);
        chk("busMode", busMode, exp);
    endtask
    // Expected data enables: selection releases false bits, else all follow drive
    function automatic logic [7:0] exp_oe(input logic phase, input logic [7:0] val,
            input logic drive);
        return phase ? val : {8{drive}};
    endfunction
    // REQ release wait: two and a half settle delays, rounded up to whole cycles
    function automatic int req_wait(input int bsd);
        return (5 * bsd + 1) / 2;
    endfunction
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Watchdog sized well past the whole sequence
    initial begin
        #(8 * 20000);
        err_count++;
        close_out();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'hfca6b8f2;
        {connReq, reselPhase, reqVal, cdVal, ioVal, msgVal, selReq, selPhase} = 8'h00;
        {ackVal, atnVal, iDrive, rstReq, tData, iData} = 20'h00000;
        tDrive = 1'b1;
        bus.diffSense = 2'h1;
        tick(8);
        arst_n = 1'b1;
        tick(STB);
        chk("drvReady early", drvReady, 1'b0);
        for (k = 0; k < 200 && drvReady !== 1'b1; k++) tick(1);
        chk("drvReady", drvReady, 1'b1);
        chk("busMode", busMode, MODE_LVD);
        mode_step(2'h2, STB / 2, MODE_LVD);
        mode_step(2'h3, STB + 8, MODE_LVD);
        mode_step(2'h2, STB + 8, MODE_HVD);
        mode_step(2'h0, STB + 8, MODE_SE);
        mode_step(2'h1, STB + 8, MODE_LVD);
        rstReq = 1'b1;
        tick(2);
        chk("rst", bus.rst, 1'b1);
        rstReq = 1'b0;
        tick(3);
        chk("rst off", bus.rst, 1'b0);
        // Random connections; first two carry all-zero and all-one initiator data
        for (i = 0; i < 6; i++) begin
            iData = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            tData = 8'($random(seed));
            {reqVal, cdVal, ioVal, msgVal, ackVal, atnVal, iDrive, tDrive} = 8'($random(seed));
            selReq = 1'b1;
            selPhase = 1'b1;
            tick(3);
            chk("sel data oe", bus.iDataOe, exp_oe(1'b1, iData, iDrive));
            connReq = 1'b1;
            reselPhase = i[0];
            for (k = 0; k < 10 && connected !== 1'b1; k++) tick(1);
            chk("connected", {connected, ignoring}, 2'h2);
            selReq = 1'b0;
            selPhase = 1'b0;
            tick(6);
            chk("init data oe", bus.iDataOe, exp_oe(1'b0, iData, iDrive));
            chk("target data oe", bus.tDataOe, exp_oe(reselPhase, tData, tDrive));
            chk("ackSeen", {ackSeen, atnSeen}, {ackVal, atnVal});
            chk("reqSeen", reqSeen, reqVal);
            chk("phase lines", {bus.cd, bus.io, bus.msg}, {cdVal, ioVal, msgVal});
            connReq = 1'b0;
            for (k = 0; k < 10 && bus.bsy !== 1'b0; k++) tick(1);
            chk("phase held", {bus.tCdOe, bus.tIoOe, bus.tMsgOe}, 3'h7);
            for (n = 0; n < 200 && bus.tReqOe !== 1'b0; n++) begin
                tick(1);
                // ACK may still be true here; the target must not pass it on
                chk("ack glitch", {ackSeen, atnSeen}, 2'h0);
                if (n == BSD) begin
                    chk("ack ignored", {ackSeen, atnSeen, ignoring}, 3'h1);
                    chk("req ignored", reqSeen, 1'b0);
                    chk("busFree early", busFree, 1'b0);
                end
            end
            chk("req wait", n, req_wait(BSD));
            chk("busFree", busFree, 1'b1);
            chk("ack released", {engaged, bus.iAckOe, bus.iAtnOe}, 3'h0);
            tick(3);
        end
        close_out();
    end
endmodule // tb
`default_nettype wire
